// ===== acmp_params.svh
`ifndef ACMP_PARAMS_SVH
`define ACMP_PARAMS_SVH

// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define IDX_DISABLE0 6'h01
`define IDX_CTRL_A 6'h08
`define IDX_CTRL_B 6'h09

// ************************************************************
// control status a field positions
// ************************************************************
`define A_POWER_OFF 7
`define A_BANDGAP 6
`define A_RESULT 5
`define A_FLAG 4
`define A_IRQ_EN 3
`define A_MUX_EN 2
`define A_MODE_HI 1
`define A_MODE_LO 0

// ************************************************************
// control status b field positions
// ************************************************************
`define B_HYST_SEL 7
`define B_HYST_LEV 6
`define B_PAIR_HI 2
`define B_PAIR_LO 0

// ************************************************************
// reset values and limits
// ************************************************************
`define RESET_DISABLE0 8'h00
`define RESET_CTRL_A 8'h00
`define RESET_CTRL_B 8'h00
`define CHANNEL_MAX 6'h0a

`endif

// ===== acmp_pkg.sv
package acmp_pkg;
   typedef enum logic [1:0] {
      POS_PIN0 = 2'h0,
      POS_PIN1 = 2'h1,
      POS_PIN2 = 2'h2,
      POS_BANDGAP = 2'h3
   } pos_src_t;
   typedef enum logic [1:0] {
      NEG_PIN0 = 2'h0,
      NEG_PIN1 = 2'h1,
      NEG_PIN2 = 2'h2,
      NEG_CONVERTER = 2'h3
   } neg_src_t;
   typedef enum logic [1:0] {
      MODE_TOGGLE = 2'h0,
      MODE_RESERVED = 2'h1,
      MODE_FALL = 2'h2,
      MODE_RISE = 2'h3
   } irq_mode_t;
endpackage

// ===== acmp_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acmp_sync_if;
   import acmp_pkg::*;
   logic raw;
   irq_mode_t mode;
   logic result;
   logic edge_event;
   modport ctrl (output raw, output mode, input result, input edge_event);
   modport sync (input raw, input mode, output result, output edge_event);
endinterface
`default_nettype wire

// ===== analog_comparator_control.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "acmp_params.svh"
`default_nettype none
module analog_comparator_control #(
   parameter int ADDR_W = 12,
   parameter int PIN_COUNT = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter state
   input wire logic converter_enable,
   input wire logic [5:0] converter_channel_field,
   // analog comparator control
   input wire logic comparator_raw,
   output acmp_pkg::pos_src_t positive_source,
   output acmp_pkg::neg_src_t negative_source,
   output logic [3:0] negative_channel,
   output logic comparator_power_off,
   output logic hysteresis_enable,
   output logic hysteresis_level,
   // interrupt
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   output logic irq_request,
   // digital input buffers
   input wire logic [PIN_COUNT-1:0] pin_digital_in,
   output logic [PIN_COUNT-1:0] pin_digital_read,
   output logic [PIN_COUNT-1:0] input_buffer_disable
);
   import acmp_pkg::*;

   // ************************************************************
   // constants
   // ************************************************************
   localparam logic [7:0] RESET_A = `RESET_CTRL_A;
   localparam logic [7:0] RESET_B = `RESET_CTRL_B;
   localparam logic [7:0] RESET_D = `RESET_DISABLE0;
   localparam logic [ADDR_W-1:0] ADDR_A = ADDR_W'({`IDX_CTRL_A, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_B = ADDR_W'({`IDX_CTRL_B, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_D = ADDR_W'({`IDX_DISABLE0, 2'b00});

   // ************************************************************
   // register state
   // ************************************************************
   logic power_off;
   logic bandgap;
   logic irq_flag;
   logic irq_enable;
   logic mux_enable;
   irq_mode_t mode;
   logic hyst_sel;
   logic hyst_lev;
   logic [2:0] pair_sel;
   logic [7:0] disable0;

   // ************************************************************
   // synchroniser and edge detector
   // ************************************************************
   acmp_sync_if link ();

   comparator_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .link(link)
   );

   assign link.raw = comparator_raw;
   assign link.mode = mode;

   // ************************************************************
   // bus decode
   // ************************************************************
   wire setup_phase;
   wire access_done;
   wire write_strobe;
   wire hit_a;
   wire hit_b;
   wire hit_d;
   wire mapped;
   wire wr_a;
   wire wr_b;
   wire wr_d;
   wire [7:0] read_a;
   wire [7:0] read_b;
   wire [7:0] read_sel;

   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready;
   assign write_strobe = access_done & pwrite & pstrb[0];
   assign hit_a = (paddr == ADDR_A);
   assign hit_b = (paddr == ADDR_B);
   assign hit_d = (paddr == ADDR_D);
   assign mapped = hit_a | hit_b | hit_d;
   assign wr_a = write_strobe & hit_a;
   assign wr_b = write_strobe & hit_b;
   assign wr_d = write_strobe & hit_d;

   assign read_a = {power_off, bandgap, link.result, irq_flag,
      irq_enable, mux_enable, mode};
   assign read_b = {hyst_sel, hyst_lev, 3'h0, pair_sel};
   assign read_sel = hit_a ? read_a :
      hit_b ? read_b :
      hit_d ? disable0 : 8'h00;

   // ************************************************************
   // apb answer, zero wait states
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~mapped;
         prdata <= (setup_phase & ~pwrite) ? {24'h0, read_sel} : 32'h0;
      end
   end

   // ************************************************************
   // control status a
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_off <= RESET_A[`A_POWER_OFF];
         bandgap <= RESET_A[`A_BANDGAP];
         irq_enable <= RESET_A[`A_IRQ_EN];
         mux_enable <= RESET_A[`A_MUX_EN];
         mode <= irq_mode_t'(RESET_A[`A_MODE_HI:`A_MODE_LO]);
      end else if (wr_a) begin
         power_off <= pwdata[`A_POWER_OFF];
         bandgap <= pwdata[`A_BANDGAP];
         irq_enable <= pwdata[`A_IRQ_EN];
         mux_enable <= pwdata[`A_MUX_EN];
         mode <= irq_mode_t'(pwdata[`A_MODE_HI:`A_MODE_LO]);
      end
   end

   // ************************************************************
   // interrupt flag, set wins over clear
   // ************************************************************
   wire flag_clear;
   wire next_irq_flag;
   wire next_irq_enable;
   wire next_irq_request;

   assign flag_clear = irq_vector_ack | (wr_a & pwdata[`A_FLAG]);
   assign next_irq_flag = link.edge_event | (irq_flag & ~flag_clear);
   assign next_irq_enable = wr_a ? pwdata[`A_IRQ_EN] : irq_enable;
   assign next_irq_request = next_irq_flag & next_irq_enable & global_irq_enable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag <= RESET_A[`A_FLAG];
         irq_request <= 1'b0;
      end else begin
         irq_flag <= next_irq_flag;
         irq_request <= next_irq_request;
      end
   end

   // ************************************************************
   // control status b and input disable
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hyst_sel <= RESET_B[`B_HYST_SEL];
         hyst_lev <= RESET_B[`B_HYST_LEV];
         pair_sel <= RESET_B[`B_PAIR_HI:`B_PAIR_LO];
      end else if (wr_b) begin
         hyst_sel <= pwdata[`B_HYST_SEL];
         hyst_lev <= pwdata[`B_HYST_LEV];
         pair_sel <= pwdata[`B_PAIR_HI:`B_PAIR_LO];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disable0 <= RESET_D;
      end else if (wr_d) begin
         disable0 <= pwdata[7:0];
      end
   end

   // ************************************************************
   // input selection
   // ************************************************************
   wire use_converter;
   pos_src_t pair_pos;
   neg_src_t pair_neg;
   pos_src_t next_positive;
   neg_src_t next_negative;
   wire [3:0] next_channel;

   assign use_converter = mux_enable & ~converter_enable
      & (converter_channel_field <= `CHANNEL_MAX);
   assign pair_pos = pair_sel[2] ? POS_PIN2 :
      pair_sel[1] ? POS_PIN1 : POS_PIN0;
   assign pair_neg = (pair_sel == 3'h0) ? NEG_PIN1 :
      (pair_sel == 3'h1) ? NEG_PIN2 :
      (pair_sel == 3'h2) ? NEG_PIN0 :
      (pair_sel == 3'h3) ? NEG_PIN2 :
      (pair_sel == 3'h4) ? NEG_PIN0 : NEG_PIN1;
   assign next_positive = bandgap ? POS_BANDGAP : pair_pos;
   assign next_negative = use_converter ? NEG_CONVERTER : pair_neg;
   assign next_channel = use_converter ? converter_channel_field[3:0] : 4'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         positive_source <= POS_PIN0;
         negative_source <= NEG_PIN1;
         negative_channel <= 4'h0;
      end else begin
         positive_source <= next_positive;
         negative_source <= next_negative;
         negative_channel <= next_channel;
      end
   end

   // ************************************************************
   // power and hysteresis
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comparator_power_off <= 1'b0;
         hysteresis_enable <= 1'b0;
         hysteresis_level <= 1'b0;
      end else begin
         comparator_power_off <= power_off;
         hysteresis_enable <= hyst_sel;
         hysteresis_level <= hyst_sel & hyst_lev;
      end
   end

   // ************************************************************
   // digital input buffers per pin
   // ************************************************************
   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i++) begin : g_pin
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_digital_read[i] <= 1'b0;
               input_buffer_disable[i] <= 1'b0;
            end else begin
               pin_digital_read[i] <= pin_digital_in[i] & ~disable0[i];
               input_buffer_disable[i] <= disable0[i];
            end
         end
      end
   endgenerate

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_flag_set: assert property (
      link.edge_event |=> irq_flag)
      else $error("edge event did not set flag");
   a_flag_clear: assert property (
      (irq_flag && irq_vector_ack && !link.edge_event) |=> !irq_flag)
      else $error("vector did not clear flag");
   a_flag_w1c: assert property (
      (wr_a && pwdata[`A_FLAG] && !link.edge_event) |=> !irq_flag)
      else $error("write one did not clear flag");
   a_irq_gate: assert property (
      ##1 (irq_request == (irq_flag && irq_enable && $past(global_irq_enable))))
      else $error("request not gated by flag enable and global bit");
   a_neg_converter: assert property (
      (mux_enable && !converter_enable && converter_channel_field == 6'h05)
      |=> (negative_source == NEG_CONVERTER && negative_channel == 4'h5))
      else $error("converter pin not chosen as negative");
   a_neg_dedicated: assert property (
      (!mux_enable || converter_enable) |=> negative_source != NEG_CONVERTER)
      else $error("converter pin used while disqualified");
   a_pair_table: assert property (
      (!bandgap && !mux_enable && pair_sel == 3'h3)
      |=> (positive_source == POS_PIN1 && negative_source == NEG_PIN2))
      else $error("pair select 011 mapped wrong");
   a_bandgap_pos: assert property (
      bandgap |=> positive_source == POS_BANDGAP)
      else $error("bandgap did not replace positive input");
   a_power_path: assert property (
      (wr_a && pwdata[`A_POWER_OFF]) |=> ##1 comparator_power_off)
      else $error("power off write not applied");
   a_hyst_level: assert property (
      (hyst_sel && hyst_lev) |=> (hysteresis_enable && hysteresis_level))
      else $error("hysteresis level not applied");
   a_pin_forced: assert property (
      disable0[0] |=> (!pin_digital_read[0] && input_buffer_disable[0]))
      else $error("disabled pin does not read zero");
   a_apb_ready: assert property (
      setup_phase |=> (pready && pslverr == !$past(mapped)))
      else $error("apb answer wrong");
   a_irq_blocked: assert property (
      (wr_a && !pwdata[`A_IRQ_EN]) |=> !irq_request)
      else $error("enable write of zero did not block request");
   a_channel_idle: assert property (
      (negative_source != NEG_CONVERTER) |-> (negative_channel == 4'h0))
      else $error("channel shown while converter not selected");
   a_strobe_ignored: assert property (
      (access_done && pwrite && !pstrb[0]) |=> $stable(disable0))
      else $error("write without lane strobe took effect");
   a_unmapped_ignored: assert property (
      (access_done && pwrite && !mapped) |=> ($stable(disable0) && $stable(pair_sel)))
      else $error("unmapped write changed a register");

   c_flag_set: cover property (!irq_flag ##1 irq_flag);
   c_request: cover property (irq_request);
   c_converter_neg: cover property (negative_source == NEG_CONVERTER);
   c_unmapped: cover property (pready && pslverr);
endmodule
`default_nettype wire

// ===== analog_comparator_control_bench.sv
`timescale 1ns/1ps
`include "acmp_params.svh"
`default_nettype none
module analog_comparator_control_bench;
   import acmp_pkg::*;
   localparam logic [11:0] AD_DIS = {4'h0, `IDX_DISABLE0, 2'b00};
   localparam logic [11:0] AD_A = {4'h0, `IDX_CTRL_A, 2'b00};
   localparam logic [11:0] AD_B = {4'h0, `IDX_CTRL_B, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h1;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic converter_enable = 1'b0;
   logic [5:0] converter_channel_field = 6'h00;
   logic comparator_raw;
   pos_src_t positive_source;
   neg_src_t negative_source;
   logic [3:0] negative_channel;
   logic comparator_power_off;
   logic hysteresis_enable;
   logic hysteresis_level;
   logic global_irq_enable = 1'b0;
   logic irq_vector_ack = 1'b0;
   logic irq_request;
   logic [7:0] pin_digital_in = 8'h00;
   logic [7:0] pin_digital_read;
   logic [7:0] input_buffer_disable;
   int pin_mv [3] = '{200, 500, 300};
   int conv_mv [16];
   int n_fail = 0;
   int checked = 0;

   always #20 pclk = ~pclk;

   analog_comparator_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .converter_enable,
      .converter_channel_field, .comparator_raw, .positive_source, .negative_source,
      .negative_channel, .comparator_power_off, .hysteresis_enable, .hysteresis_level,
      .global_irq_enable, .irq_vector_ack, .irq_request, .pin_digital_in,
      .pin_digital_read, .input_buffer_disable);

   analog_front_model i_front (.positive_source, .negative_source, .negative_channel,
      .comparator_power_off, .pin_mv, .conv_mv, .comparator_raw);

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] d, input logic e);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 8'h00, rd, err);
      chk({err, rd}, {e, 24'h0, d});
   endtask

   // pin0 against pin1 crosses the threshold
   task automatic set_raw(input logic v);
      @(posedge pclk);
      pin_mv[0] <= v ? 800 : 200;
      cyc(5);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      rd_chk(AD_DIS, 8'h00, 1'b0);
      rd_chk(AD_A, 8'h00, 1'b0);
      rd_chk(AD_B, 8'h00, 1'b0);
      rd_chk(12'h040, 8'h00, 1'b1);
      chk(positive_source, POS_PIN0);
      chk(negative_source, NEG_PIN1);
   endtask

   task automatic t_pairs();
      logic [1:0] pt [8] = '{0, 0, 1, 1, 2, 2, 2, 2};
      logic [1:0] nt [8] = '{1, 2, 0, 2, 0, 1, 1, 1};
      for (int s = 0; s < 8; s++) begin
         wr(AD_B, 8'(s));
         cyc(2);
         chk({positive_source, negative_source}, {pt[s], nt[s]});
      end
      wr(AD_A, 8'h40);
      cyc(2);
      chk(positive_source, POS_BANDGAP);
      wr(AD_A, 8'h00);
      wr(AD_B, 8'h00);
   endtask

   task automatic t_mux();
      logic [2:0] sl [6] = '{0, 1, 2, 3, 4, 7};
      wr(AD_A, 8'h04);
      for (int c = 0; c <= 10; c += 5) begin
         converter_channel_field <= 6'(c);
         for (int i = 0; i < 6; i++) begin
            wr(AD_B, {5'h0, sl[i]});
            cyc(2);
            chk(positive_source, sl[i][2] ? 2 : (sl[i][1] ? 1 : 0));
            chk({negative_source, negative_channel}, {NEG_CONVERTER, 4'(c)});
         end
      end
      converter_enable <= 1'b1;
      wr(AD_B, 8'h03);
      cyc(2);
      chk({positive_source, negative_source}, {POS_PIN1, NEG_PIN2});
      converter_enable <= 1'b0;
      wr(AD_A, 8'h00);
      cyc(2);
      chk({positive_source, negative_source}, {POS_PIN1, NEG_PIN2});
      wr(AD_B, 8'h00);
   endtask

   // irq enable stays clear while the mode changes
   task automatic t_modes();
      logic f;
      for (int m = 0; m < 4; m++) begin
         wr(AD_A, 8'h10 | 8'(m));
         set_raw(1'b1);
         f = (m == 0 || m == 3);
         rd_chk(AD_A, 8'h20 | {3'h0, f, 4'h0} | 8'(m), 1'b0);
         wr(AD_A, 8'h10 | 8'(m));
         set_raw(1'b0);
         f = (m == 0 || m == 2);
         rd_chk(AD_A, {3'h0, f, 4'h0} | 8'(m), 1'b0);
      end
      wr(AD_A, 8'h10);
   endtask

   task automatic t_irq();
      global_irq_enable <= 1'b1;
      wr(AD_A, 8'h08);
      set_raw(1'b1);
      chk(irq_request, 1'b1);
      irq_vector_ack <= 1'b1;
      @(posedge pclk);
      irq_vector_ack <= 1'b0;
      cyc(2);
      chk(irq_request, 1'b0);
      rd_chk(AD_A, 8'h28, 1'b0);
      global_irq_enable <= 1'b0;
      set_raw(1'b0);
      chk(irq_request, 1'b0);
      global_irq_enable <= 1'b1;
      cyc(2);
      chk(irq_request, 1'b1);
      wr(AD_A, 8'h00);
      cyc(1);
      chk(irq_request, 1'b0);
      rd_chk(AD_A, 8'h10, 1'b0);
      wr(AD_A, 8'h10);
      rd_chk(AD_A, 8'h00, 1'b0);
   endtask

   task automatic t_misc();
      logic [7:0] hv [3] = '{8'hc0, 8'h80, 8'h40};
      logic [1:0] he [3] = '{2'b11, 2'b10, 2'b00};
      for (int i = 0; i < 3; i++) begin
         wr(AD_B, hv[i]);
         cyc(2);
         chk({hysteresis_enable, hysteresis_level}, he[i]);
      end
      wr(AD_B, 8'hff);
      rd_chk(AD_B, 8'hc7, 1'b0);
      wr(AD_B, 8'h00);
      wr(AD_A, 8'h80);
      cyc(2);
      chk(comparator_power_off, 1'b1);
      rd_chk(AD_A, 8'h80, 1'b0);
      wr(AD_A, 8'h00);
      cyc(2);
      chk(comparator_power_off, 1'b0);
      pin_digital_in <= 8'hff;
      wr(AD_DIS, 8'ha5);
      cyc(2);
      chk({pin_digital_read, input_buffer_disable}, 16'h5aa5);
      rd_chk(AD_DIS, 8'ha5, 1'b0);
      pstrb <= 4'h0;
      wr(AD_DIS, 8'h00);
      pstrb <= 4'h1;
      wr(12'h040, 8'hff);
      rd_chk(AD_DIS, 8'ha5, 1'b0);
   endtask

   // ************************************************************
   // verdict
   // ************************************************************
   task automatic summarize();
      if (n_fail == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      n_fail++;
      summarize();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_pairs();
      t_mux();
      t_modes();
      t_irq();
      t_misc();
      summarize();
   end
endmodule
`default_nettype wire

// ===== analog_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
   import acmp_pkg::*;
#(
   parameter int BANDGAP_MV = 1100
) (
   // selection from the block
   input wire acmp_pkg::pos_src_t positive_source,
   input wire acmp_pkg::neg_src_t negative_source,
   input wire logic [3:0] negative_channel,
   input wire logic comparator_power_off,
   // pin voltages in millivolts
   input var int pin_mv [3],
   input var int conv_mv [16],
   // analog result
   output logic comparator_raw
);
   int pos_mv;
   int neg_mv;
   // ************************************************************
   // input selection and compare
   // ************************************************************
   always_comb begin
      if (positive_source == POS_BANDGAP) begin
         pos_mv = BANDGAP_MV;
      end else begin
         pos_mv = pin_mv[positive_source];
      end
      if (negative_source == NEG_CONVERTER) begin
         neg_mv = conv_mv[negative_channel];
      end else begin
         neg_mv = pin_mv[negative_source];
      end
   end
   // unpowered comparator holds low
   assign comparator_raw = !comparator_power_off && (pos_mv > neg_mv);
endmodule
`default_nettype wire

// ===== comparator_sync.sv
`timescale 1ns/1ps
`default_nettype none
module comparator_sync (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // carrier to control
   acmp_sync_if.sync link
);
   import acmp_pkg::*;

   // ************************************************************
   // two stage synchroniser and history
   // ************************************************************
   logic stage1;
   logic stage2;
   logic previous;
   wire rose;
   wire fell;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         previous <= 1'b0;
      end else begin
         stage1 <= link.raw;
         stage2 <= stage1;
         previous <= stage2;
      end
   end

   assign link.result = stage2;
   assign rose = stage2 & ~previous;
   assign fell = ~stage2 & previous;

   // ************************************************************
   // edge mode decode
   // ************************************************************
   assign link.edge_event = ((link.mode == MODE_TOGGLE) & (rose | fell))
      | ((link.mode == MODE_FALL) & fell)
      | ((link.mode == MODE_RISE) & rose);

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sync_latency: assert property (
      ##2 (link.result == $past(link.raw, 2)))
      else $error("result does not follow raw by two cycles");
   a_reserved_silent: assert property (
      (link.mode == MODE_RESERVED) |-> !link.edge_event)
      else $error("reserved mode raised an event");
   a_fall_event: assert property (
      (link.mode == MODE_FALL && $fell(link.result)) |-> link.edge_event)
      else $error("falling edge missed");
   a_rise_only: assert property (
      (link.mode == MODE_RISE && link.edge_event) |-> $rose(link.result))
      else $error("rise mode event without rising edge");
   c_toggle_event: cover property (link.mode == MODE_TOGGLE && link.edge_event);
endmodule
`default_nettype wire
